// [shared/adcci_pkg.sv]
// Constants and types shared by the converter command interpreter.
package adcci_pkg;

    // ------------------------------------------------------------------
    // Command codes, compared after masking out the don't-care bits.
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_MASK       = 8'hcf;
    localparam logic [7:0] CMD_EXIT       = 8'h00;
    localparam logic [7:0] CMD_SUBSET     = 8'hc4;
    localparam logic [7:0] CMD_SINGLE     = 8'hc6;
    localparam logic [7:0] CMD_SHORT      = 8'hc7;
    localparam logic [7:0] CMD_READ_ACQ   = 8'hc8;
    localparam logic [7:0] CMD_ACQ_READ   = 8'hc9;
    localparam logic [7:0] CMD_VREF       = 8'hca;
    localparam logic [7:0] CMD_FIRST      = 8'hcb;
    localparam logic [7:0] CMD_FIRST_READ = 8'hcd;
    localparam logic [7:0] CMD_CMP        = 8'hce;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int SHORT_LSB      = 4;
    localparam int SHORT_MSB      = 5;
    localparam int SINGLE_LSB     = 2;
    localparam int SINGLE_MSB     = 5;
    localparam int MASK_LO_MSB    = 6;
    localparam int MASK_HI_MSB    = 4;
    localparam int RES_LO_MSB     = 7;
    localparam int RES_HI_LSB     = 8;
    localparam int RES_MSB        = 9;
    localparam int NUM_CHAN       = 13;

    // ------------------------------------------------------------------
    // Reset values and limits.
    // ------------------------------------------------------------------
    localparam logic [5:0]  RET_MAX     = 6'h2c;
    localparam logic [7:0]  VREF_RESET  = 8'h00;
    localparam logic [12:0] MASK_RESET  = 13'h0000;

    typedef enum logic [10:0] {
        S_FETCH = 11'h001,
        S_ARG1  = 11'h002,
        S_ARG2  = 11'h004,
        S_ADV   = 11'h008,
        S_PICK  = 11'h010,
        S_CONV  = 11'h020,
        S_WAIT  = 11'h040,
        S_LO    = 11'h080,
        S_HI    = 11'h100,
        S_CMP   = 11'h200,
        S_SEND  = 11'h400
    } adcci_state_t;

endpackage : adcci_pkg

// [design/adcci_top.sv]
// Byte-coded interpreter for converter and comparator readout commands.
// What this block does
// - Subset read takes two channel mask bytes.
// - Convert each selected channel, append two bytes.
// - Second result byte top bits carry comparators.
// - Single read: channel in bits five to two.
// - Short read: channels zero to three, inline.
// - Advance chain, then convert and return.
// - Convert current chain channel, then advance.
// - Restart chain at first, membership kept.
// - Restart chain, then convert and return first.
// - Comparator read appends one byte, top bits.
// - Reference command copies next byte to register.
// - Zero command halts and sends return data.
// - End of program halts and sends data.
// - Return packet never exceeds 44 bytes.
// - Result low byte, then bits nine, eight.
// - First comparator bit six, second bit seven.
`timescale 1ns/1ps

module adcci_top (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Program byte stream.
    input  wire logic        prog_valid,
    input  wire logic [7:0]  prog_data,
    input  wire logic        prog_last,
    output logic             prog_ready,
    // Return byte stream.
    output logic             ret_valid,
    output logic [7:0]       ret_data,
    input  wire logic        ret_ready,
    output logic             ret_send,
    output logic [5:0]       ret_count,
    output logic             ret_overflow,
    // Converter.
    output logic             conv_start,
    output logic [3:0]       conv_chan,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_result,
    // Acquisition chain.
    output logic             chain_advance,
    output logic             chain_restart,
    input  wire logic [3:0]  chain_chan,
    // Comparator pins and reference control.
    input  wire logic [1:0]  cmp_pin,
    output logic [7:0]       vref_ctrl,
    output logic             busy
);

    adcci_pkg::adcci_state_t state_r;
    adcci_pkg::adcci_state_t state_nxt;

    logic [1:0]  cmp_meta_r;
    logic [1:0]  cmp_r;
    logic [7:0]  cmd_r;
    logic [7:0]  arg1_r;
    logic [12:0] mask_r;
    logic [1:0]  res_hi_r;
    logic [7:0]  ret_data_r;
    logic [5:0]  ret_cnt_r;
    logic        ovf_r;
    logic [3:0]  conv_chan_r;
    logic [7:0]  vref_r;
    logic        last_r;
    logic        subset_r;
    logic        acq_after_r;
    logic        restart_r;
    logic        adv_conv_r;

    logic        take;
    logic        full;
    logic        emit_done;
    logic [7:0]  cmd_m;
    logic [7:0]  cmp_byte;
    logic [12:0] mask_new;
    logic [12:0] mask_clr;
    logic [12:0] mask_nc;
    logic        more;

    // ------------------------------------------------------------------
    // Lowest set channel of a mask.
    // ------------------------------------------------------------------
    function automatic logic [3:0] lowest(input logic [12:0] m);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = adcci_pkg::NUM_CHAN - 1; i >= 0; i--) begin
            if (m[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : lowest

    // ------------------------------------------------------------------
    // Comparator synchroniser.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmp_meta_r <= 2'h0;
            cmp_r      <= 2'h0;
        end else begin
            cmp_meta_r <= cmp_pin;
            cmp_r      <= cmp_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Decode helpers.
    // ------------------------------------------------------------------
    assign prog_ready = (state_r == adcci_pkg::S_FETCH) ||
                        (state_r == adcci_pkg::S_ARG1)  ||
                        (state_r == adcci_pkg::S_ARG2);
    assign take       = prog_ready && prog_valid;
    assign cmd_m      = prog_data & adcci_pkg::CMD_MASK;
    assign full       = (ret_cnt_r == adcci_pkg::RET_MAX);
    assign ret_valid  = ((state_r == adcci_pkg::S_LO) ||
                         (state_r == adcci_pkg::S_HI) ||
                         (state_r == adcci_pkg::S_CMP)) && !full;
    assign emit_done  = ret_ready || full;
    // Comparator 1 in bit 6, comparator 2 in bit 7.
    assign cmp_byte   = {cmp_r[1], cmp_r[0], 6'h00};
    // Bit 7 of the first mask byte is reserved, so a subset read never runs channel 7.
    assign mask_new   = {prog_data[adcci_pkg::MASK_HI_MSB:0], 1'b0,
                         arg1_r[adcci_pkg::MASK_LO_MSB:0]};
    assign mask_nc    = mask_new & (mask_new - 13'h0001);
    assign mask_clr   = mask_r & (mask_r - 13'h0001);
    assign more       = subset_r && (mask_r != adcci_pkg::MASK_RESET);

    // ------------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            adcci_pkg::S_FETCH: begin
                if (take) begin
                    state_nxt = prog_last ? adcci_pkg::S_SEND
                                          : adcci_pkg::S_FETCH;
                    unique case (cmd_m)
                        adcci_pkg::CMD_EXIT: begin
                            state_nxt = adcci_pkg::S_SEND;
                        end
                        adcci_pkg::CMD_SUBSET, adcci_pkg::CMD_SINGLE,
                        adcci_pkg::CMD_VREF: begin
                            if (!prog_last) begin
                                state_nxt = adcci_pkg::S_ARG1;
                            end
                        end
                        adcci_pkg::CMD_SHORT: begin
                            state_nxt = adcci_pkg::S_CONV;
                        end
                        adcci_pkg::CMD_READ_ACQ: begin
                            state_nxt = adcci_pkg::S_PICK;
                        end
                        adcci_pkg::CMD_ACQ_READ, adcci_pkg::CMD_FIRST,
                        adcci_pkg::CMD_FIRST_READ: begin
                            state_nxt = adcci_pkg::S_ADV;
                        end
                        adcci_pkg::CMD_CMP: begin
                            state_nxt = adcci_pkg::S_CMP;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            adcci_pkg::S_ARG1: begin
                if (take) begin
                    if ((cmd_r & adcci_pkg::CMD_MASK) ==
                        adcci_pkg::CMD_SUBSET) begin
                        state_nxt = prog_last ? adcci_pkg::S_SEND
                                              : adcci_pkg::S_ARG2;
                    end else if ((cmd_r & adcci_pkg::CMD_MASK) ==
                                 adcci_pkg::CMD_SINGLE) begin
                        state_nxt = adcci_pkg::S_CONV;
                    end else begin
                        state_nxt = prog_last ? adcci_pkg::S_SEND
                                              : adcci_pkg::S_FETCH;
                    end
                end
            end
            adcci_pkg::S_ARG2: begin
                if (take) begin
                    if (mask_new != adcci_pkg::MASK_RESET) begin
                        state_nxt = adcci_pkg::S_CONV;
                    end else begin
                        state_nxt = prog_last ? adcci_pkg::S_SEND
                                              : adcci_pkg::S_FETCH;
                    end
                end
            end
            adcci_pkg::S_ADV: begin
                if (adv_conv_r) begin
                    state_nxt = adcci_pkg::S_PICK;
                end else begin
                    state_nxt = last_r ? adcci_pkg::S_SEND
                                       : adcci_pkg::S_FETCH;
                end
            end
            adcci_pkg::S_PICK: begin
                state_nxt = adcci_pkg::S_CONV;
            end
            adcci_pkg::S_CONV: begin
                state_nxt = adcci_pkg::S_WAIT;
            end
            adcci_pkg::S_WAIT: begin
                if (conv_done) begin
                    state_nxt = adcci_pkg::S_LO;
                end
            end
            adcci_pkg::S_LO: begin
                if (emit_done) begin
                    state_nxt = adcci_pkg::S_HI;
                end
            end
            adcci_pkg::S_HI: begin
                if (emit_done) begin
                    if (more) begin
                        state_nxt = adcci_pkg::S_CONV;
                    end else if (acq_after_r) begin
                        state_nxt = adcci_pkg::S_ADV;
                    end else begin
                        state_nxt = last_r ? adcci_pkg::S_SEND
                                           : adcci_pkg::S_FETCH;
                    end
                end
            end
            adcci_pkg::S_CMP: begin
                if (emit_done) begin
                    state_nxt = last_r ? adcci_pkg::S_SEND
                                       : adcci_pkg::S_FETCH;
                end
            end
            adcci_pkg::S_SEND: begin
                state_nxt = adcci_pkg::S_FETCH;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= adcci_pkg::S_FETCH;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Command and argument capture.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd_r       <= 8'h00;
            arg1_r      <= 8'h00;
            last_r      <= 1'b0;
            subset_r    <= 1'b0;
            acq_after_r <= 1'b0;
            restart_r   <= 1'b0;
            adv_conv_r  <= 1'b0;
            vref_r      <= adcci_pkg::VREF_RESET;
        end else if (state_r == adcci_pkg::S_SEND) begin
            last_r <= 1'b0;
        end else if (take) begin
            last_r <= prog_last;
            if (state_r == adcci_pkg::S_FETCH) begin
                cmd_r       <= prog_data;
                subset_r    <= (cmd_m == adcci_pkg::CMD_SUBSET);
                acq_after_r <= (cmd_m == adcci_pkg::CMD_READ_ACQ);
                restart_r   <= (cmd_m == adcci_pkg::CMD_FIRST) ||
                               (cmd_m == adcci_pkg::CMD_FIRST_READ);
                adv_conv_r  <= (cmd_m == adcci_pkg::CMD_ACQ_READ) ||
                               (cmd_m == adcci_pkg::CMD_FIRST_READ);
            end else if (state_r == adcci_pkg::S_ARG1) begin
                arg1_r <= prog_data;
                if ((cmd_r & adcci_pkg::CMD_MASK) == adcci_pkg::CMD_VREF) begin
                    vref_r <= prog_data;
                end
            end
        end else if (state_r == adcci_pkg::S_HI && emit_done) begin
            // Chain advance follows the readout exactly once.
            if (acq_after_r && !more) begin
                adv_conv_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel selection and converter result.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mask_r      <= adcci_pkg::MASK_RESET;
            conv_chan_r <= 4'h0;
            res_hi_r    <= 2'h0;
        end else if (take && state_r == adcci_pkg::S_FETCH &&
                     cmd_m == adcci_pkg::CMD_SHORT) begin
            conv_chan_r <= {2'h0, prog_data[adcci_pkg::SHORT_MSB:
                                            adcci_pkg::SHORT_LSB]};
        end else if (take && state_r == adcci_pkg::S_ARG1) begin
            conv_chan_r <= prog_data[adcci_pkg::SINGLE_MSB:
                                     adcci_pkg::SINGLE_LSB];
        end else if (take && state_r == adcci_pkg::S_ARG2) begin
            conv_chan_r <= lowest(mask_new);
            mask_r      <= mask_nc;
        end else if (state_r == adcci_pkg::S_HI && emit_done && more) begin
            conv_chan_r <= lowest(mask_r);
            mask_r      <= mask_clr;
        end else if (state_r == adcci_pkg::S_PICK) begin
            conv_chan_r <= chain_chan;
        end else if (state_r == adcci_pkg::S_WAIT && conv_done) begin
            res_hi_r <= conv_result[adcci_pkg::RES_MSB:adcci_pkg::RES_HI_LSB];
        end
    end

    // ------------------------------------------------------------------
    // Return data and byte count.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ret_data_r <= 8'h00;
        end else if (state_r == adcci_pkg::S_WAIT && conv_done) begin
            ret_data_r <= conv_result[adcci_pkg::RES_LO_MSB:0];
        end else if (state_r == adcci_pkg::S_LO && emit_done) begin
            // Comparators overwrite the top of the high byte.
            ret_data_r <= cmp_byte | {6'h00, res_hi_r};
        end else if (take && state_r == adcci_pkg::S_FETCH &&
                     cmd_m == adcci_pkg::CMD_CMP) begin
            ret_data_r <= cmp_byte;
        end
    end

    // Bytes past the limit are dropped and flagged rather than stalling.
    always_ff @(posedge core_clk) begin
        if (rst || state_r == adcci_pkg::S_SEND) begin
            ret_cnt_r <= 6'h00;
            ovf_r     <= 1'b0;
        end else if (ret_valid && ret_ready) begin
            ret_cnt_r <= ret_cnt_r + 6'h01;
        end else if (full && (state_r == adcci_pkg::S_LO ||
                              state_r == adcci_pkg::S_HI ||
                              state_r == adcci_pkg::S_CMP)) begin
            ovf_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign ret_data      = ret_data_r;
    assign ret_count     = ret_cnt_r;
    assign ret_overflow  = ovf_r;
    assign ret_send      = (state_r == adcci_pkg::S_SEND);
    assign conv_start    = (state_r == adcci_pkg::S_CONV);
    assign conv_chan     = conv_chan_r;
    assign chain_advance = (state_r == adcci_pkg::S_ADV) && !restart_r;
    assign chain_restart = (state_r == adcci_pkg::S_ADV) && restart_r;
    assign vref_ctrl     = vref_r;
    assign busy          = (state_r != adcci_pkg::S_FETCH);

endmodule : adcci_top

// [tb/adcci_chk.sv]
// Port assertions for the converter command interpreter.
`timescale 1ns/1ps

module adcci_chk (
    // Clock and reset.
    input wire logic       core_clk,
    input wire logic       rst,
    // Program stream.
    input wire logic       prog_valid,
    input wire logic [7:0] prog_data,
    input wire logic       prog_ready,
    input wire logic       busy,
    // Return stream.
    input wire logic       ret_valid,
    input wire logic [7:0] ret_data,
    input wire logic       ret_ready,
    input wire logic       ret_send,
    input wire logic [5:0] ret_count,
    input wire logic       ret_overflow,
    // Converter.
    input wire logic       conv_start,
    input wire logic       conv_done,
    input wire logic [9:0] conv_result
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // A dropped low byte never sets hi_r, so overflowed results are skipped.
    logic       lo_r;
    logic       hi_r;
    logic [9:0] res_r;
    always_ff @(posedge core_clk) begin
        if (rst || ret_send || conv_start) begin
            lo_r <= 1'b0;
            hi_r <= 1'b0;
        end else if (conv_done) begin
            lo_r  <= 1'b1;
            res_r <= conv_result;
        end else if (ret_valid && ret_ready) begin
            lo_r <= 1'b0;
            hi_r <= lo_r;
        end
    end
    sequence s_exit_taken;
        prog_valid && prog_ready && !busy && prog_data == 8'h00;
    endsequence
    sequence s_result_in;
        conv_done && ret_count != 6'h2c;
    endsequence
    property p_exit; s_exit_taken |-> ##[1:3] ret_send; endproperty
    a_exit: assert property (p_exit) else $error("no send on exit");
    property p_low;
        s_result_in |=> ret_valid && ret_data == res_r[7:0];
    endproperty
    a_low: assert property (p_low) else $error("bad low byte");
    property p_high;
        hi_r && ret_valid |-> ret_data[5:0] == {4'h0, res_r[9:8]};
    endproperty
    a_high: assert property (p_high) else $error("bad high byte");
    property p_hold;
        ret_valid && !ret_ready |=> ret_valid && $stable(ret_data);
    endproperty
    a_hold: assert property (p_hold) else $error("offer dropped");
    property p_send;
        ret_send |=> !ret_send && ret_count == 6'h00 && !ret_overflow;
    endproperty
    a_send: assert property (p_send) else $error("send not clean");
    property p_limit; ret_count <= 6'h2c; endproperty
    a_limit: assert property (p_limit) else $error("count over");
    property p_count;
        ret_valid && ret_ready |=> ret_count == $past(ret_count) + 6'h01;
    endproperty
    a_count: assert property (p_count) else $error("count step");
    property p_flag; $rose(ret_overflow) |-> ret_count == 6'h2c; endproperty
    a_flag: assert property (p_flag) else $error("early overflow");
endmodule : adcci_chk

bind adcci_top adcci_chk u_chk (.*);

// [tb/adcci_conv_model.sv]
// Converter and acquisition chain model for the interpreter bench.
`timescale 1ns/1ps

module adcci_conv_model (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Converter.
    input  wire logic       conv_start,
    input  wire logic [3:0] conv_chan,
    input  wire logic [3:0] lat,
    output logic            conv_done,
    output logic [9:0]      conv_result,
    // Chain.
    input  wire logic       chain_advance,
    input  wire logic       chain_restart,
    output logic [3:0]      chain_chan
);
    logic [3:0] wait_r;
    logic [3:0] ch_r;
    logic [1:0] idx_r;
    logic [9:0] res;
    // Idle cycles show the inverse, so a stale sample can never pass.
    assign res = {ch_r[1:0], ~ch_r, ch_r};
    assign conv_result = conv_done ? res : ~res;
    assign chain_chan = idx_r == 2'h0 ? 4'h3 : idx_r == 2'h1 ? 4'h7 : 4'ha;
    always_ff @(posedge core_clk) begin
        conv_done <= !rst && wait_r == 4'h1;
        if (rst) begin
            wait_r <= 4'h0;
        end else if (conv_start) begin
            wait_r <= lat;
            ch_r   <= conv_chan;
        end else if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst || chain_restart) begin
            idx_r <= 2'h0;
        end else if (chain_advance) begin
            idx_r <= idx_r == 2'h2 ? 2'h0 : idx_r + 2'h1;
        end
    end
endmodule : adcci_conv_model

// [tb/adcci_tb_top.sv]
// Self-checking bench for the converter command interpreter.
`timescale 1ns/1ps

module adcci_tb_top;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       prog_valid = 1'b0;
    logic [7:0] prog_data = 8'h00;
    logic       prog_last = 1'b0;
    logic       ret_ready = 1'b0;
    logic [1:0] cmp_pin = 2'h0;
    logic [3:0] lat = 4'h1;
    logic       stall = 1'b0;
    int         sends = 0;
    logic [6:0] sent_st = 7'h00;
    logic       prog_ready;
    logic       ret_valid;
    logic [7:0] ret_data;
    logic       ret_send;
    logic [5:0] ret_count;
    logic       ret_overflow;
    logic       conv_start;
    logic [3:0] conv_chan;
    logic       conv_done;
    logic [9:0] conv_result;
    logic       chain_advance;
    logic       chain_restart;
    logic [3:0] chain_chan;
    logic [7:0] vref_ctrl;
    logic       busy;
    int         failures = 0;
    int         checks_done = 0;
    logic [7:0] got[$];
    logic [7:0] exp[$];
    logic [7:0] prog[$];

    adcci_top DUT (.*);
    adcci_conv_model u_model (.*);

    initial forever #20 core_clk = ~core_clk;

    // Stalling on alternate cycles makes the design hold each offer.
    always @(posedge core_clk) begin
        ret_ready <= stall ? ~ret_ready : 1'b1;
        if (ret_valid === 1'b1 && ret_ready === 1'b1) got.push_back(ret_data);
        if (ret_send === 1'b1) begin
            sends   <= sends + 1;
            sent_st <= {ret_overflow, ret_count};
        end
    end

    task automatic chk_byte(string what, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk_byte

    task automatic put(logic [7:0] b, logic l);
        prog_valid <= 1'b1;
        prog_data  <= b;
        prog_last  <= l;
        @(posedge core_clk);
        while (prog_ready !== 1'b1) @(posedge core_clk);
    endtask : put

    task automatic setup(logic [1:0] c);
        cmp_pin <= c;
        exp.delete();
        repeat (3) @(posedge core_clk);
    endtask : setup

    // Channels are packed one per nibble, lowest nibble first.
    task automatic add(logic [19:0] seq, int n);
        logic [9:0] r;
        for (int i = 0; i < n; i++) begin
            r = {seq[4*i+:2], ~seq[4*i+:4], seq[4*i+:4]};
            exp.push_back(r[7:0]);
            exp.push_back({cmp_pin, 4'h0, r[9:8]});
        end
    endtask : add

    // Only the bench counts sends, so a missing halt shows as a count of 0.
    task automatic run(logic s, logic [3:0] l);
        int s0;
        s0 = sends;
        stall <= s;
        lat   <= l;
        got.delete();
        foreach (prog[i]) put(prog[i], i == prog.size() - 1);
        prog_valid <= 1'b0;
        for (int n = 0; n < 800 && sends == s0; n++) @(posedge core_clk);
        chk_byte("ret_send", 8'h01, 8'(sends - s0));
        chk_byte("ret_count", 8'(exp.size()), {2'h0, sent_st[5:0]});
        foreach (exp[i]) chk_byte("ret_data", exp[i], got[i]);
    endtask : run

    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk_byte("vref_ctrl", 8'h00, vref_ctrl);
        chk_byte("ret_count", 8'h00, {2'h0, ret_count});
        prog = '{8'hc4, 8'h05, 8'h11};
        setup(2'b01);
        add(20'h0c820, 4);
        run(1'b1, 4'h6);
        prog = '{8'hc6, 8'h2c, 8'hf7, 8'h00};
        setup(2'b10);
        add(20'h0003b, 2);
        run(1'b1, 4'h1);
        prog = '{8'hca, 8'h5a, 8'hce};
        setup(2'b01);
        exp.push_back(8'h40);
        run(1'b0, 4'h1);
        chk_byte("vref_ctrl", 8'h5a, vref_ctrl);
        prog = '{8'hc9, 8'hc8, 8'hcd, 8'hc9, 8'hcb, 8'hc8};
        setup(2'b10);
        add(20'h37377, 5);
        run(1'b1, 4'h2);
        prog = '{8'hc4, 8'h7f, 8'h1f, 8'hc4, 8'h7f, 8'h1f};
        setup(2'b01);
        for (int k = 0; k < 26; k++) begin
            if (k % 13 != 7 && exp.size() < 44) add(20'(k % 13), 1);
        end
        run(1'b0, 4'h1);
        chk_byte("ret_overflow", 8'h01, {7'h00, sent_st[6]});
        final_report();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        final_report();
    end
endmodule : adcci_tb_top
